// ---- bsr_sram.sv ----
// split-port double data rate burst memory: input registers, array, read launch
`timescale 1ns/100ps

// =========================================================================
// Notes on behaviour
// - read and write ports run independently and concurrently
// - read address captured at rising edge of the input clock
// - write address captured at rising edge of the complementary input clock
// - all accesses start at a rising edge of the input clock
// - write words captured one per input clock edge, one per complementary edge
// - one read word driven per output clock edge and complementary edge
// - each location holds two words of 18 or 36 bits, moved in order
// - every access is exactly a two-word burst
// - each port has its own select input
// - every synchronous input goes through input registers first
// - read data passes output registers on the output clock pair
// - array writes are clocked by the input clock from the registered request
// - one shared address bus carries both read and write addresses
// - logic acts on rising clock edges only
// - separate input and output data buses, no turnaround
// - write select active low; deselected write ignores data inputs
// - read select active low; deselect lets pending read finish, then floats
// - address 19 or 18 bits; ignored when its port is deselected
module bsr_sram #(
    parameter int AW         = bsr_pkg::ADDR_W_NARROW, // address width
    parameter int DW         = bsr_pkg::WORD_W_NARROW, // word width
    parameter bit SINGLE_CLK = 1'b0                    // output clocks tied to input clocks
)(
    input  wire logic          clk_sys_i,             // input clock, rising edge
    input  wire logic          clk_cmp_i,             // complementary input clock
    input  wire logic          clk_out_i,             // output clock
    input  wire logic          clk_out_cmp_i,         // complementary output clock
    input  wire logic          arst_n_i,              // asynchronous reset, active low
    input  wire logic          read_port_select_n_i,  // read port select, active low
    input  wire logic          write_port_select_n_i, // write port select, active low
    input  wire logic [AW-1:0] addr_i,                // shared address bus
    input  wire logic [DW-1:0] wr_data_i,             // write data bus
    output logic      [DW-1:0] rd_data_rise_o,        // read word for the output clock edge
    output logic      [DW-1:0] rd_data_fall_o,        // read word for the complementary edge
    output logic               rd_data_oe_o           // read data pins driven
);
    import bsr_pkg::*;

    // =====================================================================
    // state
    // =====================================================================
    typedef struct packed {
        logic          rd_go;
        logic [AW-1:0] raddr;
        logic          wr_go;
        logic [DW-1:0] wd0;
        logic          tgl;
        logic [DW-1:0] rw0;
        logic [DW-1:0] rw1;
        logic [AW-1:0] last_waddr;
    } bsr_k_t;

    typedef struct packed {
        logic [AW-1:0] waddr;
        logic [DW-1:0] wd1;
    } bsr_c_t;

    localparam int DEPTH = 2 ** AW;

    bsr_k_t                     k_reg;
    bsr_k_t                     k_next;
    bsr_c_t                     c_reg;
    bsr_c_t                     c_next;
    logic [BURST_WORDS*DW-1:0]  mem [0:DEPTH-1];
    logic [BURST_WORDS*DW-1:0]  rd_peek;
    logic [BURST_WORDS*DW-1:0]  wr_word;
    logic [BURST_WORDS*DW-1:0]  wr_peek;

    bsr_rd_if #(.DW(DW)) rd_link ();

    // port deselected when its select is high
    function automatic logic port_on(input logic sel_n);
        port_on = !sel_n;
    endfunction

    assign rd_peek = mem[k_reg.raddr];
    assign wr_word = {c_reg.wd1, k_reg.wd0};
    assign wr_peek = mem[k_reg.last_waddr];

    // =====================================================================
    // input clock domain: port selects, read address, first write word
    // =====================================================================
    always_comb
    begin
        k_next = k_reg;
        // both selects sampled together, neither waits on the other
        k_next.rd_go = port_on(read_port_select_n_i);
        k_next.wr_go = port_on(write_port_select_n_i);
        if (port_on(read_port_select_n_i))
        begin
            k_next.raddr = addr_i;
        end
        if (port_on(write_port_select_n_i))
        begin
            k_next.wd0 = wr_data_i;
        end
        // a read registered last edge fetches both words now
        if (k_reg.rd_go)
        begin
            k_next.rw0 = rd_peek[DW-1:0];
            k_next.rw1 = rd_peek[BURST_WORDS*DW-1:DW];
            k_next.tgl = !k_reg.tgl;
        end
        k_next.last_waddr = c_reg.waddr;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            k_reg <= '{rd_go: RST_SEL, raddr: '0, wr_go: RST_SEL, wd0: '0,
                       tgl: RST_TGL, rw0: '0, rw1: '0, last_waddr: '0};
        end
        else
        begin
            k_reg <= k_next;
        end
    end

    // =====================================================================
    // complementary input clock: write address and second write word
    // =====================================================================
    // complement is phase-locked to the input clock, so reading wr_go here
    // half a cycle after it was set is a plain related-clock path
    always_comb
    begin
        c_next = c_reg;
        if (k_reg.wr_go)
        begin
            c_next.waddr = addr_i;
            c_next.wd1   = wr_data_i;
        end
    end

    always_ff @(posedge clk_cmp_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            c_reg <= '{waddr: '0, wd1: '0};
        end
        else
        begin
            c_reg <= c_next;
        end
    end

    // =====================================================================
    // array
    // =====================================================================
    // write commits on the input clock edge after the burst is complete;
    // a read of the same location in that edge still returns the old pair
    always_ff @(posedge clk_sys_i)
    begin
        if (k_reg.wr_go)
        begin
            mem[c_reg.waddr] <= wr_word;
        end
    end

    // =====================================================================
    // hand-off to the output stage
    // =====================================================================
    // results held until the next read; if the output clock is slow, reads
    // closer together than the crossing latency overwrite unsent results
    assign rd_link.tgl   = k_reg.tgl;
    assign rd_link.word0 = k_reg.rw0;
    assign rd_link.word1 = k_reg.rw1;

    // read data on its own bus, never shared with write data
    bsr_qout #(
        .DW         (DW),
        .SINGLE_CLK (SINGLE_CLK)
    ) u_qout (
        .clk_out_i     (clk_out_i),
        .clk_out_cmp_i (clk_out_cmp_i),
        .arst_n_i      (arst_n_i),
        .rd            (rd_link),
        .q_rise_o      (rd_data_rise_o),
        .q_fall_o      (rd_data_fall_o),
        .q_oe_o        (rd_data_oe_o)
    );

    // =====================================================================
    // checks
    // =====================================================================
    sequence rd_taken_s;
        k_reg.rd_go ##1 (k_reg.tgl != $past(k_reg.tgl));
    endsequence

    sequence rd_idle_s;
        !k_reg.rd_go ##1 $stable(k_reg.tgl);
    endsequence

    rd_launch_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !read_port_select_n_i |=> rd_taken_s)
        else $error("selected read did not launch");

    rd_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        read_port_select_n_i |=> rd_idle_s)
        else $error("deselected read port launched a read");

    raddr_hold_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        read_port_select_n_i |=> $stable(k_reg.raddr))
        else $error("read address taken while deselected");

    rd_pair_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        k_reg.rd_go |=> {k_reg.rw1, k_reg.rw0} == $past(rd_peek))
        else $error("read burst does not match array pair");

    wd0_hold_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        write_port_select_n_i |=> $stable(k_reg.wd0))
        else $error("write data taken while write port deselected");

    wr_commit_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        k_reg.wr_go |=> wr_peek == $past(wr_word))
        else $error("write burst not committed to array");

    waddr_hold_a: assert property (@(posedge clk_cmp_i) disable iff (!arst_n_i)
        !k_reg.wr_go |=> $stable(c_reg.waddr))
        else $error("write address taken without a write");

    wd1_take_a: assert property (@(posedge clk_cmp_i) disable iff (!arst_n_i)
        k_reg.wr_go |=> c_reg.wd1 == $past(wr_data_i))
        else $error("second write word not captured");
endmodule

// ---- bsr_pkg.sv ----
// shared constants of the split-port double data rate burst memory
package bsr_pkg;

    // word and address widths of the two configurations
    localparam int WORD_W_NARROW = 18;
    localparam int WORD_W_WIDE   = 36;
    localparam int ADDR_W_NARROW = 19;
    localparam int ADDR_W_WIDE   = 18;

    // every access moves exactly this many words
    localparam int BURST_WORDS = 2;

    // flops in the toggle synchroniser of the output domain
    localparam int SYNC_STAGES = 2;

    // values after reset
    localparam logic RST_SEL   = 1'b0;
    localparam logic RST_TGL   = 1'b0;
    localparam logic RST_OE    = 1'b0;

endpackage

// ---- bsr_rd_if.sv ----
// read-result carrier from the input clock domain to the output stage
`timescale 1ns/100ps

interface bsr_rd_if #(
    parameter int DW = bsr_pkg::WORD_W_NARROW  // word width
);
    logic          tgl;    // flips once per finished array read
    logic [DW-1:0] word0;  // first word of the burst, held until next read
    logic [DW-1:0] word1;  // second word of the burst, held until next read

    modport src (output tgl, output word0, output word1);
    modport dst (input tgl, input word0, input word1);
endinterface

// ---- bsr_qout.sv ----
// read data output registers on the output clock pair
`timescale 1ns/100ps

module bsr_qout #(
    parameter int DW         = bsr_pkg::WORD_W_NARROW, // word width
    parameter bit SINGLE_CLK = 1'b0                    // output clocks are the input clocks
)(
    input  wire logic          clk_out_i,     // output clock, rising edge
    input  wire logic          clk_out_cmp_i, // complementary output clock, rising edge
    input  wire logic          arst_n_i,      // asynchronous reset, active low
    bsr_rd_if.dst              rd,            // read results from the input domain
    output logic      [DW-1:0] q_rise_o,      // word sent while the output clock is high
    output logic      [DW-1:0] q_fall_o,      // word sent after the complementary edge
    output logic               q_oe_o         // read port drives its data pins
);
    import bsr_pkg::*;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] sync;
        logic                   seen;
        logic [DW-1:0]          q_rise;
        logic [DW-1:0]          w1_hold;
        logic                   oe;
    } bsr_oc_t;

    bsr_oc_t       oc_reg;
    bsr_oc_t       oc_next;
    logic [DW-1:0] qf_reg;
    logic          tgl_now;

    // =====================================================================
    // output clock domain
    // =====================================================================
    always_comb
    begin
        oc_next = oc_reg;
        oc_next.sync = {oc_reg.sync[SYNC_STAGES-2:0], rd.tgl};
        // single clock mode: source shares our clock, no crossing needed
        tgl_now = SINGLE_CLK ? rd.tgl : oc_reg.sync[SYNC_STAGES-1];
        oc_next.seen = tgl_now;
        if (tgl_now != oc_reg.seen)
        begin
            oc_next.q_rise  = rd.word0;
            oc_next.w1_hold = rd.word1;
            oc_next.oe      = 1'b1;
        end
        else
        begin
            oc_next.oe = 1'b0;
        end
    end

    always_ff @(posedge clk_out_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            oc_reg <= '{sync: '0, seen: RST_TGL, q_rise: '0, w1_hold: '0, oe: RST_OE};
        end
        else
        begin
            oc_reg <= oc_next;
        end
    end

    // second word leaves on the complementary edge, half a cycle later
    always_ff @(posedge clk_out_cmp_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            qf_reg <= '0;
        end
        else
        begin
            qf_reg <= oc_reg.w1_hold;
        end
    end

    assign q_rise_o = oc_reg.q_rise;
    assign q_fall_o = qf_reg;
    assign q_oe_o   = oc_reg.oe;

    // =====================================================================
    // checks
    // =====================================================================
    sequence new_result_s;
        oc_reg.seen != tgl_now;
    endsequence

    q_launch_a: assert property (@(posedge clk_out_i) disable iff (!arst_n_i)
        new_result_s |=> oc_reg.oe && oc_reg.q_rise == $past(rd.word0))
        else $error("read word not launched on output clock");

    q_float_a: assert property (@(posedge clk_out_i) disable iff (!arst_n_i)
        (oc_reg.oe && oc_reg.seen == tgl_now) |=> !oc_reg.oe)
        else $error("read port kept driving after burst");

    q_fall_a: assert property (@(posedge clk_out_cmp_i) disable iff (!arst_n_i)
        1'b1 |=> qf_reg == $past(oc_reg.w1_hold))
        else $error("second word not sent on complementary edge");
endmodule

// ---- bsr_ctl_model.sv ----
// memory controller model driving both ports of the burst memory
`timescale 1ns/100ps

// =========================================================================
// controller pins
module bsr_ctl_model #(
    parameter int AW = 19, // address width
    parameter int DW = 18  // word width
)(
    input  wire logic          clk_sys_i,             // input clock
    input  wire logic          clk_cmp_i,             // complementary input clock
    output logic               read_port_select_n_o,  // read select, active low
    output logic               write_port_select_n_o, // write select, active low
    output logic      [AW-1:0] addr_o,                // shared address bus
    output logic      [DW-1:0] wr_data_o              // write data bus
);
    initial
    begin
        read_port_select_n_o  = 1'b1;
        write_port_select_n_o = 1'b1;
        addr_o                = '0;
        wr_data_o             = '0;
    end

    // =====================================================================
    // one input clock cycle: selects, read address and word0 stand over the
    // next clk_sys_i rise, write address and word1 over the clk_cmp_i rise
    // after it; left just after that complementary rise
    // deselected cycles still carry live values so ignored pins are exercised
    task automatic xfer(input bit rd, input logic [AW-1:0] ra, input bit wr,
                        input logic [AW-1:0] wa, input logic [DW-1:0] w0,
                        input logic [DW-1:0] w1);
        read_port_select_n_o  = !rd;
        write_port_select_n_o = !wr;
        addr_o                = ra;
        wr_data_o             = w0;
        @(posedge clk_sys_i);
        #1;
        addr_o    = wa;
        wr_data_o = w1;
        @(posedge clk_cmp_i);
        #1;
    endtask
endmodule

// ---- tb.sv ----
// self-checking bench of the split-port burst memory
`timescale 1ns/100ps

module tb;
    import bsr_pkg::*;

    localparam int AW = ADDR_W_NARROW;
    localparam int DW = WORD_W_NARROW;

    // =====================================================================
    // clocks, reset and pins
    logic          clk_sys_i;
    logic          clk_out_i;
    logic          arst_n_i;
    wire logic     clk_cmp_i     = ~clk_sys_i;
    wire logic     clk_out_cmp_i = ~clk_out_i;
    logic          read_port_select_n;
    logic          write_port_select_n;
    logic [AW-1:0] addr;
    logic [DW-1:0] wr_data;
    logic [DW-1:0] rd_rise;
    logic [DW-1:0] rd_fall;
    logic          rd_oe;
    logic [DW-1:0] sc_rise;
    logic [DW-1:0] sc_fall;
    logic          sc_oe;
    logic [DW-1:0] got_sc;
    int            err_total;
    int            checks;
    int            seed = 9;
    logic [2*DW-1:0] ref_mem [logic [AW-1:0]];
    logic [2*DW-1:0] exp_q [$];
    logic [2*DW-1:0] exp_sc [$];
    logic [AW-1:0]   adr [8];
    logic [DW-1:0]   got0;

    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // link clock with an odd offset so its edges drift against clk_sys_i
    initial
    begin
        clk_out_i = 1'b0;
        #3.7;
        forever #24 clk_out_i = ~clk_out_i;
    end

    bsr_sram #(.AW(AW), .DW(DW), .SINGLE_CLK(1'b0)) bsr_sram_i (
        .clk_sys_i             (clk_sys_i),
        .clk_cmp_i             (clk_cmp_i),
        .clk_out_i             (clk_out_i),
        .clk_out_cmp_i         (clk_out_cmp_i),
        .arst_n_i              (arst_n_i),
        .read_port_select_n_i  (read_port_select_n),
        .write_port_select_n_i (write_port_select_n),
        .addr_i                (addr),
        .wr_data_i             (wr_data),
        .rd_data_rise_o        (rd_rise),
        .rd_data_fall_o        (rd_fall),
        .rd_data_oe_o          (rd_oe)
    );

    // same pins, output stage on the input clock pair (single clock mode)
    bsr_sram #(.AW(AW), .DW(DW), .SINGLE_CLK(1'b1)) bsr_sram_sc_i (
        .clk_sys_i             (clk_sys_i),
        .clk_cmp_i             (clk_cmp_i),
        .clk_out_i             (clk_sys_i),
        .clk_out_cmp_i         (clk_cmp_i),
        .arst_n_i              (arst_n_i),
        .read_port_select_n_i  (read_port_select_n),
        .write_port_select_n_i (write_port_select_n),
        .addr_i                (addr),
        .wr_data_i             (wr_data),
        .rd_data_rise_o        (sc_rise),
        .rd_data_fall_o        (sc_fall),
        .rd_data_oe_o          (sc_oe)
    );

    bsr_ctl_model #(.AW(AW), .DW(DW)) bsr_ctl_model_i (
        .clk_sys_i             (clk_sys_i),
        .clk_cmp_i             (clk_cmp_i),
        .read_port_select_n_o  (read_port_select_n),
        .write_port_select_n_o (write_port_select_n),
        .addr_o                (addr),
        .wr_data_o             (wr_data)
    );

    // =====================================================================
    // helpers
    function automatic logic [AW-1:0] rnd_a();
        return AW'($random(seed));
    endfunction

    function automatic logic [DW-1:0] rnd_w();
        return DW'($random(seed));
    endfunction

    function automatic logic [2*DW-1:0] expect_rd(input logic [AW-1:0] a);
        return ref_mem.exists(a) ? ref_mem[a] : 'x;
    endfunction

    task automatic chk(input logic [2*DW-1:0] got, input logic [2*DW-1:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) bsr_ctl_model_i.xfer(1'b0, rnd_a(), 1'b0, rnd_a(), rnd_w(), rnd_w());
    endtask

    // reads are spaced so the unbuffered output crossing is never overrun
    task automatic op(input bit rd, input logic [AW-1:0] ra, input bit wr,
                      input logic [AW-1:0] wa, input logic [DW-1:0] w0,
                      input logic [DW-1:0] w1);
        if (rd)
        begin
            exp_q.push_back(expect_rd(ra));
            exp_sc.push_back(expect_rd(ra));
        end
        bsr_ctl_model_i.xfer(rd, ra, wr, wa, w0, w1);
        if (wr)
            ref_mem[wa] = {w1, w0};
        if (rd)
            idle(24);
    endtask

    task automatic summarize();
        if (err_total == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // =====================================================================
    // read monitor: one burst per oe pulse, word0 then word1
    always @(posedge clk_out_i)
    begin
        #1;
        if (rd_oe === 1'b1)
        begin
            got0 = rd_rise;
            @(posedge clk_out_cmp_i);
            #1;
            chk({rd_fall, got0}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
        end
    end

    // single clock mode: word0 on the input clock, word1 on its complement
    always @(posedge clk_sys_i)
    begin
        #1;
        if (sc_oe === 1'b1)
        begin
            got_sc = sc_rise;
            @(posedge clk_cmp_i);
            #1;
            chk({sc_fall, got_sc}, exp_sc.size() > 0 ? exp_sc.pop_front() : 'x);
        end
    end

    initial
    begin
        #50000;
        err_total++;
        summarize();
    end

    // =====================================================================
    // main sequence
    initial
    begin
        arst_n_i  = 1'b0;
        err_total = 0;
        checks    = 0;
        repeat (8) @(posedge clk_sys_i);
        #1;
        chk({rd_fall, rd_rise}, '0);
        chk((2*DW)'(rd_oe), '0);
        chk({sc_fall, sc_rise}, '0);
        chk((2*DW)'(sc_oe), '0);
        arst_n_i = 1'b1;
        idle(2);
        for (int i = 0; i < 8; i++)
            adr[i] = (i == 0) ? '0 : (i == 1) ? '1 : rnd_a();
        // back-to-back writes, boundary addresses first
        for (int i = 0; i < 8; i++)
            op(1'b0, rnd_a(), 1'b1, adr[i], rnd_w(), rnd_w());
        for (int i = 0; i < 8; i++)
            op(1'b1, adr[i], 1'b0, adr[i], rnd_w(), rnd_w());
        // concurrent read and write on the shared address bus
        op(1'b1, adr[2], 1'b1, adr[3], rnd_w(), rnd_w());
        op(1'b1, adr[3], 1'b0, rnd_a(), rnd_w(), rnd_w());
        // same location read and written in one cycle gives the old burst
        op(1'b1, adr[4], 1'b1, adr[4], rnd_w(), rnd_w());
        op(1'b1, adr[4], 1'b0, adr[4], rnd_w(), rnd_w());
        idle(30);
        chk((2*DW)'(exp_q.size()), '0);
        chk((2*DW)'(rd_oe), '0);
        chk((2*DW)'(exp_sc.size()), '0);
        chk((2*DW)'(sc_oe), '0);
        summarize();
    end
endmodule
